/* shared/rsx_consts.vh */
// Constants for the rotate, set, sleep and subtract execution block.
// Assumes it is included by bare name from the design files.
`ifndef RSX_CONSTS_VH
`define RSX_CONSTS_VH

// ****************************************
// APB register byte offsets
// ****************************************
`define RSX_OFS_INSTR    12'h000
`define RSX_OFS_WORK     12'h004
`define RSX_OFS_FLAGS    12'h008
`define RSX_OFS_BANK     12'h00C
`define RSX_OFS_CTRL     12'h010
`define RSX_OFS_INDEX    12'h014
`define RSX_OFS_POWER    12'h018
`define RSX_OFS_EADDR    12'h01C
`define RSX_OFS_FILE     12'h100
`define RSX_FILE_WORDS   32

// ****************************************
// Flag bit positions
// ****************************************
`define RSX_FLG_C        0
`define RSX_FLG_DC       1
`define RSX_FLG_Z        2
`define RSX_FLG_OV       3
`define RSX_FLG_N        4

// ****************************************
// Opcode patterns (upper bits of the word; sleep is the whole word)
// ****************************************
`define RSX_OPC_RLN      6'h11
`define RSX_OPC_RRC      6'h0C
`define RSX_OPC_RRN      6'h10
`define RSX_OPC_SET      7'h34
`define RSX_OPC_SUB      6'h15
`define RSX_OPC_SLEEP    16'h0003

// ****************************************
// ALU operation codes
// ****************************************
`define RSX_ALU_RLN      3'h0
`define RSX_ALU_RRC      3'h1
`define RSX_ALU_RRN      3'h2
`define RSX_ALU_SET      3'h3
`define RSX_ALU_SUB      3'h4

// ****************************************
// Addressing and reset values
// ****************************************
`define RSX_IDX_LIMIT    8'h5F
`define RSX_ACC_SPLIT    8'h60
`define RSX_ACC_HIGH     4'hF
`define RSX_RST_BANK     4'h0
`define RSX_RST_WD       8'h00

`endif

/* rtl/rsx_alu.v */
// Combinational result and flag unit for the rotate, set and subtract ops.
// Assumes the caller holds operands stable for the process phase.
`timescale 1ns/100ps
`default_nettype none
`include "rsx_consts.vh"

module rsx_alu (
    input  wire [2:0] op_in,
    input  wire [7:0] file_in,
    input  wire [7:0] work_in,
    input  wire [4:0] flags_in,
    output reg  [7:0] result_out,
    output reg  [4:0] flags_out
);

    reg [8:0] diff;
    reg [4:0] half;

    // ****************************************
    // Result and flag selection
    // ****************************************
    always @* begin
        result_out = file_in;
        flags_out  = flags_in;
        // Borrow is inverted carry, so add the inverted file plus carry
        diff = {1'b0, work_in} + {1'b0, ~file_in}
             + {8'h00, flags_in[`RSX_FLG_C]};
        half = {1'b0, work_in[3:0]} + {1'b0, ~file_in[3:0]}
             + {4'h0, flags_in[`RSX_FLG_C]};
        case (op_in)
            `RSX_ALU_RLN: begin
                result_out = {file_in[6:0], file_in[7]};
            end
            `RSX_ALU_RRC: begin
                result_out = {flags_in[`RSX_FLG_C], file_in[7:1]};
                flags_out[`RSX_FLG_C] = file_in[0];
            end
            `RSX_ALU_RRN: begin
                result_out = {file_in[0], file_in[7:1]};
            end
            `RSX_ALU_SET: begin
                result_out = 8'hFF;
            end
            `RSX_ALU_SUB: begin
                result_out = diff[7:0];
                flags_out[`RSX_FLG_C]  = diff[8];
                flags_out[`RSX_FLG_DC] = half[4];
                flags_out[`RSX_FLG_OV] = (work_in[7] ^ file_in[7])
                                       & (work_in[7] ^ diff[7]);
            end
            default: begin
                result_out = file_in;
            end
        endcase
        // Rotates and subtract share the N and Z update; set leaves flags
        if (op_in != `RSX_ALU_SET) begin
            flags_out[`RSX_FLG_N] = result_out[7];
            flags_out[`RSX_FLG_Z] = (result_out == 8'h00);
        end
    end

endmodule // rsx_alu

`default_nettype wire

/* rtl/rsx_exec.v */
// Execution block for rotate, set-all-ones, sleep and subtract-with-borrow.
// Assumes an APB master on the same clock and wake pins from another domain.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "rsx_consts.vh"

module rsx_exec (
    input  wire        REF_CLK_IN,
    input  wire        RSTN_IN,
    input  wire        PSEL_IN,
    input  wire        PENABLE_IN,
    input  wire        PWRITE_IN,
    input  wire [11:0] PADDR_IN,
    input  wire [31:0] PWDATA_IN,
    input  wire        WAKE_IN,
    input  wire        WD_WAKE_IN,
    output reg         PREADY_OUT,
    output reg         PSLVERR_OUT,
    output reg  [31:0] PRDATA_OUT,
    output reg         SLEEP_OUT,
    output reg         WD_CLEAR_OUT,
    output reg  [7:0]  WD_COUNT_OUT
);

    // ****************************************
    // Phase encoding
    // ****************************************
    localparam [2:0] PH_IDLE    = 3'h0;
    localparam [2:0] PH_DECODE  = 3'h1;
    localparam [2:0] PH_READ    = 3'h2;
    localparam [2:0] PH_PROCESS = 3'h3;
    localparam [2:0] PH_WRITE   = 3'h4;

    reg  [2:0]  phase_reg;
    reg  [15:0] instr_reg;
    reg  [7:0]  work_reg;
    reg  [4:0]  flags_reg;
    reg  [3:0]  bank_reg;
    reg         ext_en_reg;
    reg  [7:0]  index_reg;
    reg  [11:0] eaddr_reg;
    reg  [7:0]  operand_reg;
    reg  [7:0]  result_reg;
    reg  [4:0]  rflags_reg;
    reg  [2:0]  op_reg;
    reg         to_file_reg;
    reg         wr_flags_reg;
    reg         is_sleep_reg;
    reg         timeout_flag_reg;
    reg         power_down_flag_reg;
    reg  [1:0]  wake_sync_reg;
    reg  [1:0]  wd_sync_reg;
    reg  [7:0]  file_mem [0:`RSX_FILE_WORDS-1];

    wire        apb_setup;
    wire        apb_done;
    wire        instr_hit;
    wire        file_hit;
    wire [4:0]  file_idx;
    wire        mapped;
    wire [7:0]  f_addr;
    wire        acc_bit;
    wire        dst_bit;
    wire [7:0]  alu_result;
    wire [4:0]  alu_flags;
    reg  [11:0] eaddr_next;
    reg  [2:0]  op_next;
    reg         valid_next;
    reg         sleep_next;
    reg         dst_next;
    reg  [31:0] rdata_next;
    integer     i;

    assign apb_setup = PSEL_IN & PENABLE_IN & ~PREADY_OUT;
    assign apb_done  = PSEL_IN & PENABLE_IN & PREADY_OUT;
    assign file_hit  = ({PADDR_IN[11:7], 7'h00} == `RSX_OFS_FILE)
                     & (PADDR_IN[1:0] == 2'h0);
    assign file_idx  = PADDR_IN[6:2];
    assign instr_hit = (PADDR_IN == `RSX_OFS_INSTR);
    assign mapped    = file_hit | (PADDR_IN[11:5] == 7'h00
                     & PADDR_IN[1:0] == 2'h0);
    assign f_addr    = instr_reg[7:0];
    assign acc_bit   = instr_reg[8];
    assign dst_bit   = instr_reg[9];

    // ****************************************
    // Decode of the held instruction word
    // ****************************************
    always @* begin
        op_next    = `RSX_ALU_RLN;
        valid_next = 1'b1;
        sleep_next = 1'b0;
        dst_next   = dst_bit;
        if (instr_reg[15:10] == `RSX_OPC_RLN) begin
            op_next = `RSX_ALU_RLN;
        end else if (instr_reg[15:10] == `RSX_OPC_RRC) begin
            op_next = `RSX_ALU_RRC;
        end else if (instr_reg[15:10] == `RSX_OPC_RRN) begin
            op_next = `RSX_ALU_RRN;
        end else if (instr_reg[15:9] == `RSX_OPC_SET) begin
            op_next  = `RSX_ALU_SET;
            dst_next = 1'b1;                   // Set always targets the file
        end else if (instr_reg[15:10] == `RSX_OPC_SUB) begin
            op_next = `RSX_ALU_SUB;
        end else if (instr_reg == `RSX_OPC_SLEEP) begin
            sleep_next = 1'b1;
        end else begin
            valid_next = 1'b0;                 // Other words run as no-ops
        end
    end

    // ****************************************
    // Effective file address
    // ****************************************
    always @* begin
        if (acc_bit) begin
            eaddr_next = {bank_reg, f_addr};
        end else if (ext_en_reg && f_addr <= `RSX_IDX_LIMIT) begin
            eaddr_next = {4'h0, index_reg + f_addr};
        end else if (f_addr < `RSX_ACC_SPLIT) begin
            eaddr_next = {4'h0, f_addr};
        end else begin
            eaddr_next = {`RSX_ACC_HIGH, f_addr};
        end
    end

    rsx_alu i_rsx_alu (
        .op_in      (op_reg),
        .file_in    (operand_reg),
        .work_in    (work_reg),
        .flags_in   (flags_reg),
        .result_out (alu_result),
        .flags_out  (alu_flags)
    );

    // ****************************************
    // Wake pin synchronisers
    // ****************************************
    always @(posedge REF_CLK_IN) begin
        if (!RSTN_IN) begin
            wake_sync_reg <= 2'h0;
            wd_sync_reg   <= 2'h0;
        end else begin
            wake_sync_reg <= {wake_sync_reg[0], WAKE_IN};
            wd_sync_reg   <= {wd_sync_reg[0], WD_WAKE_IN};
        end
    end

    // ****************************************
    // Four-phase instruction sequencer
    // ****************************************
    // Each phase is one clock so a known word takes four clocks; an unknown word returns to idle after decode.
    always @(posedge REF_CLK_IN) begin
        if (!RSTN_IN) begin
            phase_reg           <= PH_IDLE;
            op_reg              <= `RSX_ALU_RLN;
            to_file_reg         <= 1'b0;
            wr_flags_reg        <= 1'b0;
            is_sleep_reg        <= 1'b0;
            eaddr_reg           <= 12'h000;
            operand_reg         <= 8'h00;
            result_reg          <= 8'h00;
            rflags_reg          <= 5'h00;
            SLEEP_OUT           <= 1'b0;
            WD_CLEAR_OUT        <= 1'b0;
            WD_COUNT_OUT        <= `RSX_RST_WD;
            timeout_flag_reg    <= 1'b1;
            power_down_flag_reg <= 1'b1;
        end else begin
            WD_CLEAR_OUT <= 1'b0;
            case (phase_reg)
                PH_IDLE: begin
                    // A refused word stays refused though the core went idle
                    if (apb_done && PWRITE_IN && instr_hit && !SLEEP_OUT
                        && !PSLVERR_OUT) begin
                        phase_reg <= PH_DECODE;
                    end
                end
                PH_DECODE: begin
                    op_reg       <= op_next;
                    to_file_reg  <= valid_next & ~sleep_next & dst_next;
                    wr_flags_reg <= valid_next & ~sleep_next
                                  & (op_next != `RSX_ALU_SET);
                    is_sleep_reg <= sleep_next;
                    eaddr_reg    <= eaddr_next;
                    phase_reg    <= valid_next ? PH_READ : PH_IDLE;
                end
                PH_READ: begin
                    operand_reg <= file_mem[eaddr_reg[4:0]];
                    phase_reg   <= PH_PROCESS;
                end
                PH_PROCESS: begin
                    result_reg <= alu_result;
                    rflags_reg <= alu_flags;
                    phase_reg  <= PH_WRITE;
                end
                PH_WRITE: begin
                    if (is_sleep_reg) begin
                        WD_COUNT_OUT        <= `RSX_RST_WD;
                        WD_CLEAR_OUT        <= 1'b1;
                        timeout_flag_reg    <= 1'b1;
                        power_down_flag_reg <= 1'b0;
                        SLEEP_OUT           <= 1'b1;
                    end
                    phase_reg <= PH_IDLE;
                end
                default: begin
                    phase_reg <= PH_IDLE;
                end
            endcase
            // Wake is only honoured while halted
            if (SLEEP_OUT && (wake_sync_reg[1] || wd_sync_reg[1])) begin
                SLEEP_OUT <= 1'b0;
                if (wd_sync_reg[1]) begin
                    timeout_flag_reg <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Software-visible registers and file storage
    // ****************************************
    // The instruction write back wins over a software write in the same clock.
    always @(posedge REF_CLK_IN) begin
        if (!RSTN_IN) begin
            instr_reg  <= 16'h0000;
            work_reg   <= 8'h00;
            flags_reg  <= 5'h00;
            bank_reg   <= `RSX_RST_BANK;
            ext_en_reg <= 1'b0;
            index_reg  <= 8'h00;
            for (i = 0; i < `RSX_FILE_WORDS; i = i + 1) begin
                file_mem[i] <= 8'h00;
            end
        end else begin
            if (apb_done && PWRITE_IN) begin
                if (instr_hit && phase_reg == PH_IDLE && !SLEEP_OUT
                    && !PSLVERR_OUT) begin
                    instr_reg <= PWDATA_IN[15:0];
                end
                if (PADDR_IN == `RSX_OFS_WORK) work_reg <= PWDATA_IN[7:0];
                if (PADDR_IN == `RSX_OFS_FLAGS) flags_reg <= PWDATA_IN[4:0];
                if (PADDR_IN == `RSX_OFS_BANK) bank_reg <= PWDATA_IN[3:0];
                if (PADDR_IN == `RSX_OFS_CTRL) ext_en_reg <= PWDATA_IN[0];
                if (PADDR_IN == `RSX_OFS_INDEX) index_reg <= PWDATA_IN[7:0];
                if (file_hit) file_mem[file_idx] <= PWDATA_IN[7:0];
            end
            if (phase_reg == PH_WRITE) begin
                if (to_file_reg) begin
                    file_mem[eaddr_reg[4:0]] <= result_reg;
                end else if (wr_flags_reg) begin
                    work_reg <= result_reg;
                end
                if (wr_flags_reg) begin
                    flags_reg <= rflags_reg;
                end
            end
        end
    end

    // ****************************************
    // Read data selection
    // ****************************************
    always @* begin
        rdata_next = 32'h00000000;
        if (file_hit) begin
            rdata_next = {24'h000000, file_mem[file_idx]};
        end else begin
            case (PADDR_IN)
                `RSX_OFS_INSTR: rdata_next = {16'h0000, instr_reg};
                `RSX_OFS_WORK:  rdata_next = {24'h000000, work_reg};
                `RSX_OFS_FLAGS: rdata_next = {27'h0000000, flags_reg};
                `RSX_OFS_BANK:  rdata_next = {28'h0000000, bank_reg};
                `RSX_OFS_CTRL:  rdata_next = {31'h00000000, ext_en_reg};
                `RSX_OFS_INDEX: rdata_next = {24'h000000, index_reg};
                `RSX_OFS_POWER: rdata_next = {28'h0000000,
                                    power_down_flag_reg, timeout_flag_reg,
                                    SLEEP_OUT, phase_reg != PH_IDLE};
                `RSX_OFS_EADDR: rdata_next = {20'h00000, eaddr_reg};
                default:        rdata_next = 32'h00000000;
            endcase
        end
    end

    // ****************************************
    // APB answer, one wait state
    // ****************************************
    // A busy or halted core refuses an instruction write with an error.
    always @(posedge REF_CLK_IN) begin
        if (!RSTN_IN) begin
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT  <= 32'h00000000;
        end else begin
            PREADY_OUT  <= apb_setup;
            PSLVERR_OUT <= apb_setup & (~mapped | (PWRITE_IN & instr_hit
                         & (phase_reg != PH_IDLE | SLEEP_OUT)));
            PRDATA_OUT  <= (apb_setup & ~PWRITE_IN) ? rdata_next
                                                    : 32'h00000000;
        end
    end

endmodule // rsx_exec

`default_nettype wire

/* verification/rsx_exec_sva.sv */
// Port checker for the rotate, set, sleep and subtract block.
// Assumes an APB master that holds each request until PREADY_OUT.
`timescale 1ns/100ps
`default_nettype none
`include "rsx_consts.vh"

module rsx_exec_chk (
    input wire logic        REF_CLK_IN,
    input wire logic        RSTN_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic        WAKE_IN,
    input wire logic        WD_WAKE_IN,
    input wire logic        PREADY_OUT,
    input wire logic        PSLVERR_OUT,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        SLEEP_OUT,
    input wire logic        WD_CLEAR_OUT,
    input wire logic [7:0]  WD_COUNT_OUT
);
    // ********
    // Properties
    // ********
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    // Finished transfer, and a write aimed at the instruction word
    wire logic done = PSEL_IN && PENABLE_IN && PREADY_OUT;
    wire logic ins_wr = PWRITE_IN && PADDR_IN == `RSX_OFS_INSTR;

    // Exactly one wait state: a stuck ready path shows at once
    chk_one_wait: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT
        |=> PREADY_OUT) else $error("ready late");
    chk_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready too long");
    chk_rdata_idle: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
        else $error("read data not zero when idle");
    chk_bad_addr: assert property (done && PADDR_IN >= 12'h020
        && PADDR_IN < `RSX_OFS_FILE |-> PSLVERR_OUT)
        else $error("unmapped access not refused");
    chk_sleep_entry: assert property (done && ins_wr
        && !PSLVERR_OUT && PWDATA_IN[15:0] == `RSX_OPC_SLEEP
        |-> ##[2:6] SLEEP_OUT) else $error("sleep did not halt");
    chk_sleep_clear: assert property ($rose(SLEEP_OUT)
        |-> WD_CLEAR_OUT && WD_COUNT_OUT == 8'h00)
        else $error("watchdog not cleared on sleep");
    chk_clear_pulse: assert property (WD_CLEAR_OUT
        |=> !WD_CLEAR_OUT) else $error("clear pulse too wide");
    chk_clear_cause: assert property ($rose(WD_CLEAR_OUT)
        |-> $rose(SLEEP_OUT)) else $error("clear without sleep");
    // Four quiet cycles flush the wake synchronisers
    chk_stay_asleep: assert property (
        (SLEEP_OUT && !WAKE_IN && !WD_WAKE_IN) [*4] |=> SLEEP_OUT)
        else $error("left sleep with no wake");
    chk_wake_up: assert property (
        SLEEP_OUT && (WAKE_IN || WD_WAKE_IN) |-> ##[1:5] !SLEEP_OUT)
        else $error("no wake from sleep");
    chk_halt_refuse: assert property (
        PSEL_IN && PENABLE_IN && !PREADY_OUT && ins_wr && SLEEP_OUT
        ##1 SLEEP_OUT |-> PSLVERR_OUT) else $error("word taken asleep");
    // An error code only ever rides on a ready cycle
    chk_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
        else $error("error without ready");
endmodule // rsx_exec_chk

bind rsx_exec rsx_exec_chk i_rsx_exec_chk (
    .REF_CLK_IN(REF_CLK_IN), .RSTN_IN(RSTN_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .WAKE_IN(WAKE_IN), .WD_WAKE_IN(WD_WAKE_IN),
    .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .PRDATA_OUT(PRDATA_OUT), .SLEEP_OUT(SLEEP_OUT),
    .WD_CLEAR_OUT(WD_CLEAR_OUT), .WD_COUNT_OUT(WD_COUNT_OUT));
`default_nettype wire

/* verification/test_rotate_set_sleep_subtract_exec.sv */
// Self-checking bench for the rotate, set, sleep and subtract block.
// Assumes APB answers with one wait state and 4-clock execution.
`timescale 1ns/100ps
`default_nettype none
`include "rsx_consts.vh"

module test_rotate_set_sleep_subtract_exec;
    logic        REF_CLK_IN = 1'h0;
    logic        RSTN_IN = 1'h0;
    logic        PSEL_IN = 1'h0;
    logic        PENABLE_IN = 1'h0;
    logic        PWRITE_IN = 1'h0;
    logic [11:0] PADDR_IN = 12'h000;
    logic [31:0] PWDATA_IN = 32'h0;
    logic        WAKE_IN = 1'h0;
    logic        WD_WAKE_IN = 1'h0;
    logic        PREADY_OUT, PSLVERR_OUT, SLEEP_OUT, WD_CLEAR_OUT;
    logic [31:0] PRDATA_OUT, r1, r2;
    logic [7:0]  WD_COUNT_OUT, f, v, w, r, idx;
    logic [3:0]  bank;
    logic [4:0]  fi, fo;
    logic [11:0] ea, fa;
    logic [15:0] ins;
    logic        a, d, ext;
    logic [32:0] exp_q[$];
    logic [5:0]  opc[4];
    int          error_cnt = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          k, op;

    rsx_exec i_rsx_exec (
        .REF_CLK_IN(REF_CLK_IN), .RSTN_IN(RSTN_IN), .PSEL_IN(PSEL_IN),
        .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
        .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .WAKE_IN(WAKE_IN),
        .WD_WAKE_IN(WD_WAKE_IN), .PREADY_OUT(PREADY_OUT),
        .PSLVERR_OUT(PSLVERR_OUT), .PRDATA_OUT(PRDATA_OUT),
        .SLEEP_OUT(SLEEP_OUT), .WD_CLEAR_OUT(WD_CLEAR_OUT),
        .WD_COUNT_OUT(WD_COUNT_OUT));

    // ********
    // Clock, report and answer checking
    // ********
    initial begin
        forever #50 REF_CLK_IN = ~REF_CLK_IN;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Compares one answer, error bit above the read data
    task automatic cmp_resp(input logic [32:0] e, input logic [32:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t answer %h expected %h", $time, g, e);
        end
    endtask

    // Oldest note against each answer; the cycle ceiling cuts a hang
    always @(posedge REF_CLK_IN) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            error_cnt++;
            test_done();
        end
        if (PREADY_OUT === 1'h1)
            cmp_resp(exp_q.pop_front(), {PSLVERR_OUT, PRDATA_OUT});
    end

    // ********
    // Bus tasks and reference model
    // ********
    // Holds the request until ready; an idle cycle follows each transfer
    task automatic apb(input logic wr, input logic [11:0] ad,
                       input logic [31:0] dt, input logic [32:0] e);
        int n;
        n = 0;
        exp_q.push_back(e);
        PSEL_IN <= 1'h1;
        PWRITE_IN <= wr;
        PADDR_IN <= ad;
        PWDATA_IN <= dt;
        @(posedge REF_CLK_IN);
        PENABLE_IN <= 1'h1;
        do begin
            @(posedge REF_CLK_IN);
            n++;
        end while (PREADY_OUT !== 1'h1 && n < 16);
        if (n == 16) begin
            error_cnt++;
            $display("BAD %0t no ready", $time);
        end
        PSEL_IN <= 1'h0;
        PENABLE_IN <= 1'h0;
        @(posedge REF_CLK_IN);
    endtask

    task automatic wr(input logic [11:0] ad, input logic [31:0] dt,
                      input logic err);
        apb(1'h1, ad, dt, {err, 32'h0});
    endtask

    task automatic rd(input logic [11:0] ad, input logic [31:0] e);
        apb(1'h0, ad, r1, {1'h0, e});
    endtask

    // Result and flags (C0 DC1 Z2 OV3 N4); op 4 is the set-all-ones
    task automatic model(input int o, output logic [7:0] res,
                         output logic [4:0] fl);
        logic [8:0] t;
        logic [4:0] h;
        fl = fi;
        res = 8'hFF;
        t = {1'h0, w} - {1'h0, v} - {8'h0, ~fi[0]};
        h = {1'h0, w[3:0]} - {1'h0, v[3:0]} - {4'h0, ~fi[0]};
        case (o)
            0: res = {v[6:0], v[7]};
            1: {res, fl[0]} = {fi[0], v};
            2: res = {v[0], v[7:1]};
            3: begin
                res = t[7:0];
                {fl[1], fl[0]} = {~h[4], ~t[8]};
                fl[3] = (w[7] != v[7]) && (res[7] != w[7]);
            end
            default: ;
        endcase
        if (o < 4) {fl[4], fl[2]} = {res[7], res == 8'h00};
    endtask

    // ********
    // Main sequence
    // ********
    initial begin
        r1 = $urandom(32'hD1677774);
        opc = '{`RSX_OPC_RLN, `RSX_OPC_RRC, `RSX_OPC_RRN, `RSX_OPC_SUB};
        repeat (2) @(posedge REF_CLK_IN);
        RSTN_IN <= 1'h1;
        @(posedge REF_CLK_IN);
        // Reset values; POWER shows timeout and power-down set
        for (k = 1; k < 8; k++)
            rd(12'(4 * k), (k == 6) ? 32'hC : 32'h0);
        apb(1'h0, 12'h020, r1, {1'h1, 32'h0});
        apb(1'h1, 12'h0FC, r1, {1'h1, 32'h0});
        // Every op, both bank modes, both sides of the 5Fh boundary
        for (k = 0; k < 60; k++) begin
            op = k % 5;
            r1 = $urandom;
            r2 = $urandom;
            {a, d, ext, bank, idx, v} = r1[22:0];
            f = (k % 3 == 0) ? 8'h5E + 8'(k % 4) : r2[15:8];
            w = r2[7:0];
            fi = r2[20:16];
            if (a) ea = {bank, f};
            else if (ext && f <= 8'h5F) ea = {4'h0, idx + f};
            else ea = {(f < 8'h60) ? 4'h0 : 4'hF, f};
            fa = `RSX_OFS_FILE + {5'h0, ea[4:0], 2'h0};
            ins = (op == 4) ? {`RSX_OPC_SET, a, f} : {opc[op], d, a, f};
            wr(`RSX_OFS_CTRL, {31'h0, ext}, 1'h0);
            wr(`RSX_OFS_BANK, {28'h0, bank}, 1'h0);
            wr(`RSX_OFS_INDEX, {24'h0, idx}, 1'h0);
            wr(`RSX_OFS_WORK, r2, 1'h0);
            wr(`RSX_OFS_FLAGS, {27'h0, fi}, 1'h0);
            wr(fa, {24'h0, v}, 1'h0);
            wr(`RSX_OFS_INSTR, {16'h0, ins}, 1'h0);
            if (k == 1) rd(`RSX_OFS_POWER, 32'hD);
            if (k % 7 == 3)
                wr(`RSX_OFS_INSTR, {16'h0, `RSX_OPC_SET, a, f},
                   1'h1);
            repeat (5) @(posedge REF_CLK_IN);
            model(op, r, fo);
            rd(`RSX_OFS_WORK, {24'h0, (op < 4 && !d) ? r : w});
            rd(`RSX_OFS_FLAGS,
               {27'h0, fo});
            rd(fa, {24'h0, (op == 4 || d) ? r : v});
            rd(`RSX_OFS_EADDR, {20'h0, ea});
        end
        // An unknown word runs as a no-op and leaves W alone
        wr(`RSX_OFS_WORK, 32'h5A, 1'h0);
        wr(`RSX_OFS_INSTR, 32'h0, 1'h0);
        repeat (4) @(posedge REF_CLK_IN);
        rd(`RSX_OFS_WORK, 32'h5A);
        // Sleep three times; the middle round wakes by watchdog
        for (k = 0; k < 3; k++) begin
            wr(`RSX_OFS_INSTR, {16'h0, `RSX_OPC_SLEEP}, 1'h0);
            repeat (6) @(posedge REF_CLK_IN);
            rd(`RSX_OFS_POWER, 32'h6);
            wr(`RSX_OFS_INSTR, {16'h0, `RSX_OPC_SLEEP}, 1'h1);
            if (k == 1) WD_WAKE_IN <= 1'h1;
            else WAKE_IN <= 1'h1;
            repeat (6) @(posedge REF_CLK_IN);
            WAKE_IN <= 1'h0;
            WD_WAKE_IN <= 1'h0;
            repeat (4) @(posedge REF_CLK_IN);
            rd(`RSX_OFS_POWER, (k == 1) ? 32'h0 : 32'h4);
        end
        repeat (2) @(posedge REF_CLK_IN);
        test_done();
    end
endmodule // test_rotate_set_sleep_subtract_exec
`default_nettype wire
